// ===== dv/swb_core_model.sv
// swb_core_model: core decode side that offers instruction words to the unit.
// assumes the bench pulses go for one cycle per word while no offer is pending.
`timescale 1ns/1ps
module swb_core_model (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic go,
  input wire logic [15:0] go_word,
  input wire logic instr_ready,
  output logic instr_valid,
  output logic [15:0] instr_word
);
  // hold the offer until ready is seen at an edge, then scramble the stale word
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      instr_valid <= 1'b0;
      instr_word <= 16'h0000;
    end else if (instr_valid && instr_ready) begin
      instr_valid <= 1'b0;
      instr_word <= ~instr_word;
    end else if (go) begin
      instr_valid <= 1'b1;
      instr_word <= go_word;
    end
  end
endmodule : swb_core_model

// ===== dv/tb_subtract_with_borrow_unit.sv
// tb_subtract_with_borrow_unit: self-checking bench for the subtract-with-borrow unit.
// assumes the file store and all control registers are reached over the register port.
`timescale 1ns/1ps
module tb_subtract_with_borrow_unit;
  import swb_pkg::*;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic go = 1'b0;
  logic [15:0] go_word = 16'h0000;
  logic instr_valid, instr_ready, busy, done, ill_op;
  logic [15:0] instr_word;
  logic [DATA_W-1:0] accum_out, bus_rdata;
  logic [ST_W-1:0] status_out;
  logic [7:0] bus_addr = 8'h00;
  logic [DATA_W-1:0] bus_wdata = 8'h00;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic rd_d = 1'b0;
  logic [7:0] rd_q[$];
  logic [1:0] end_q[$];
  int num_errors = 0;
  int compares = 0;

  // 100 ns core clock
  always #50 ref_clk = ~ref_clk;

  swb_core_model swb_core_model_inst (.ref_clk(ref_clk), .arst_n(arst_n), .go(go),
    .go_word(go_word), .instr_ready(instr_ready), .instr_valid(instr_valid),
    .instr_word(instr_word));

  swb_unit swb_unit_inst (.ref_clk(ref_clk), .arst_n(arst_n), .instr_valid(instr_valid),
    .instr_word(instr_word), .instr_ready(instr_ready), .busy(busy), .done(done),
    .ill_op(ill_op), .accum_out(accum_out), .status_out(status_out), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata));

  task automatic wrap_up;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // one-cycle register write, entered just after a rising edge; the next call or bus_idle
  // lowers the strobe, so no strobe is assigned twice in one time step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus_addr <= a;
    bus_wdata <= d;
    bus_rd <= 1'b0;
    bus_wr <= 1'b1;
    @(posedge ref_clk);
  endtask : wr

  // one-cycle register read; the expected byte waits in the queue
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    rd_q.push_back(exp);
    bus_addr <= a;
    bus_wr <= 1'b0;
    bus_rd <= 1'b1;
    @(posedge ref_clk);
  endtask : rd

  // release both strobes before anything that lets edges pass
  task automatic bus_idle;
    bus_wr <= 1'b0;
    bus_rd <= 1'b0;
  endtask : bus_idle

  // 12-bit value as lo byte then hi nibble
  task automatic set12(input logic [7:0] a, input logic [11:0] v);
    wr(a, v[7:0]);
    wr(a + 8'h04, {4'h0, v[11:8]});
  endtask : set12

  // offer one word, count negedges until done or ill_op shows
  task automatic run(input logic [15:0] w, input logic [1:0] kind);
    int n;
    n = 0;
    end_q.push_back(kind);
    bus_idle();
    go_word <= w;
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    do begin
      @(negedge ref_clk);
      n++;
      check({7'h00, busy}, (n >= 2) ? 8'h01 : 8'h00);
      check({7'h00, instr_ready}, (n >= 2 && n <= 4) ? 8'h00 : 8'h01);
    end while (!(done || ill_op) && n < 20);
    // one edge for the offer to appear, then the take edge and three phase edges
    check(n[7:0], 8'h05);
    if (n >= 20) wrap_up;
    @(posedge ref_clk);
  endtask : run

  // watch outputs: read data the cycle after a read, end pulses as they appear
  always @(posedge ref_clk) rd_d <= bus_rd;
  always @(negedge ref_clk) begin
    if (rd_d) check(bus_rdata, rd_q.pop_front());
    if (done || ill_op) check({6'h00, done, ill_op}, {6'h00, end_q.pop_front()});
  end

  // main sequence: reset values, random operations, illegal opcode
  initial begin
    int seed;
    logic [7:0] w, fv, f;
    logic [3:0] bank;
    logic [11:0] idx, addr;
    logic c, d, a, ext;
    logic [8:0] s;
    logic [4:0] lo, st;
    seed = $urandom(82);
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    rd(OFS_ACCUM, 8'h00);
    rd(OFS_STATUS, 8'h00);
    rd(OFS_PHASE, 8'h01);
    wr(OFS_PHASE, 8'hff);
    rd(OFS_PHASE, 8'h01);
    rd(8'h30, 8'h00);
    for (int i = 0; i < 48; i++) begin
      w = 8'($urandom);
      fv = 8'($urandom);
      f = 8'($urandom);
      bank = 4'($urandom);
      idx = 12'($urandom);
      {c, d, a, ext} = 4'($urandom);
      if (i % 3 == 0) f = (i % 2) ? 8'h5f : 8'h60;
      if (a) addr = {bank, f};
      else if (ext && f <= IDX_LIMIT) addr = idx + {4'h0, f};
      else addr = {(f >= ACCESS_SPLIT) ? ACCESS_HI_BANK : ACCESS_LO_BANK, f};
      wr(OFS_ACCUM, w);
      wr(OFS_STATUS, {7'h00, c});
      wr(OFS_BANK, {4'h0, bank});
      wr(OFS_CTRL, {7'h00, ext});
      set12(OFS_IDX_LO, idx);
      set12(OFS_MADDR_LO, addr);
      wr(OFS_MDATA, fv);
      run({OPC_TOP, d, a, f}, 2'b10);
      // plain subtraction with borrow; carry and half carry are the inverted borrows
      s = {1'b0, fv} - {1'b0, w} - {8'h00, !c};
      lo = {1'b0, fv[3:0]} - {1'b0, w[3:0]} - {4'h0, !c};
      st = {s[7], (fv[7] != w[7]) && (s[7] != fv[7]), s[7:0] == 8'h00, !lo[4], !s[8]};
      rd(OFS_STATUS, {3'h0, st});
      check(accum_out, d ? w : s[7:0]);
      check({3'h0, status_out}, {3'h0, st});
      rd(OFS_ACCUM, d ? w : s[7:0]);
      rd(OFS_MDATA, d ? s[7:0] : fv);
    end
    wr(OFS_ACCUM, 8'h55);
    wr(OFS_STATUS, 8'h0a);
    run({6'h17, 2'b00, 8'h10}, 2'b01);
    rd(OFS_ACCUM, 8'h55);
    check(accum_out, 8'h55);
    rd(OFS_STATUS, 8'h0a);
    bus_idle();
    @(posedge ref_clk);
    wrap_up;
  end
endmodule : tb_subtract_with_borrow_unit

// ===== src/swb_flags.sv
// swb_flags: combinational subtract with borrow and its arithmetic flags.
// assumes the caller registers the outputs.
`timescale 1ns/1ps
module swb_flags
  import swb_pkg::*;
(
  input wire logic [DATA_W-1:0] minuend,
  input wire logic [DATA_W-1:0] subtrahend,
  input wire logic carry_in,
  output logic [DATA_W-1:0] diff,
  output logic [ST_W-1:0] flags
);

  logic [DATA_W:0] full_sum;
  logic [4:0] low_sum;

  // two's complement: f + ~w + c, carry out is not-borrow
  always_comb begin
    full_sum = {1'b0, minuend} + {1'b0, ~subtrahend} + {8'h00, carry_in};
    low_sum = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + {4'h0, carry_in};
    diff = full_sum[DATA_W-1:0];
    flags = '0;
    flags[ST_C] = full_sum[DATA_W];
    flags[ST_DC] = low_sum[4];
    flags[ST_Z] = (full_sum[DATA_W-1:0] == 8'h00);
    flags[ST_OV] = (minuend[7] != subtrahend[7]) && (full_sum[7] != minuend[7]);
    flags[ST_N] = full_sum[7];
  end

endmodule : swb_flags

// ===== src/swb_pkg.sv
// swb_pkg: constants shared by the subtract-with-borrow unit and its flag generator.
// assumes a single core clock and a plain 8-bit register port.
package swb_pkg;

  // data and address widths
  localparam int DATA_W = 8;
  localparam int BANK_W = 4;
  localparam int FA_W = BANK_W + DATA_W;

  // instruction word fields
  localparam int OP_LSB = 10;
  localparam logic [5:0] OPC_TOP = 6'h16;
  localparam int D_BIT = 9;
  localparam int A_BIT = 8;

  // indexed literal offset and quick bank mapping
  localparam logic [7:0] IDX_LIMIT = 8'h5f;
  localparam logic [7:0] ACCESS_SPLIT = 8'h80;
  localparam logic [BANK_W-1:0] ACCESS_HI_BANK = 4'hf;
  localparam logic [BANK_W-1:0] ACCESS_LO_BANK = 4'h0;

  // status bit positions
  localparam int ST_C = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z = 2;
  localparam int ST_OV = 3;
  localparam int ST_N = 4;
  localparam int ST_W = 5;

  // register port offsets
  localparam logic [7:0] OFS_ACCUM = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_BANK = 8'h08;
  localparam logic [7:0] OFS_CTRL = 8'h0c;
  localparam logic [7:0] OFS_IDX_LO = 8'h10;
  localparam logic [7:0] OFS_IDX_HI = 8'h14;
  localparam logic [7:0] OFS_MADDR_LO = 8'h18;
  localparam logic [7:0] OFS_MADDR_HI = 8'h1c;
  localparam logic [7:0] OFS_MDATA = 8'h20;
  localparam logic [7:0] OFS_PHASE = 8'h24;

  // values after reset
  localparam logic [DATA_W-1:0] RST_ACCUM = 8'h00;
  localparam logic [ST_W-1:0] RST_STATUS = 5'h00;
  localparam logic [BANK_W-1:0] RST_BANK = 4'h0;
  localparam logic RST_EXT_EN = 1'b0;
  localparam logic [FA_W-1:0] RST_IDX = 12'h000;

  // one-hot phase codes
  typedef enum logic [4:0] {
    SWB_IDLE = 5'h01,
    SWB_Q1 = 5'h02,
    SWB_Q2 = 5'h04,
    SWB_Q3 = 5'h08,
    SWB_Q4 = 5'h10
  } swb_phase_t;

endpackage : swb_pkg

// ===== src/swb_unit.sv
// swb_unit: four-phase datapath for the subtract-with-borrow instruction with its file store.
// assumes the core presents one instruction word with a valid strobe and reset comes from the core.
//
// Local design decisions: strobed register access and the address map.
`timescale 1ns/1ps

module swb_unit
  import swb_pkg::*;
#(
  parameter int FILE_DEPTH = 4096
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  output logic instr_ready,
  output logic busy,
  output logic done,
  output logic ill_op,
  output logic [DATA_W-1:0] accum_out,
  output logic [ST_W-1:0] status_out,
  input wire logic [7:0] bus_addr,
  input wire logic [DATA_W-1:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [DATA_W-1:0] bus_rdata
);

  // resolve the 12-bit file address from the instruction fields
  function automatic logic [FA_W-1:0] resolve_addr(
    input logic [7:0] f,
    input logic a,
    input logic [BANK_W-1:0] bank,
    input logic ext,
    input logic [FA_W-1:0] base
  );
    logic [FA_W-1:0] r;
    r = '0;
    if (a) begin
      r = {bank, f};
    end else if (ext && (f <= IDX_LIMIT)) begin
      r = base + {4'h0, f};
    end else if (f < ACCESS_SPLIT) begin
      r = {ACCESS_LO_BANK, f};
    end else begin
      r = {ACCESS_HI_BANK, f};
    end
    return r;
  endfunction : resolve_addr

  // phase and datapath state
  swb_phase_t state_r, state_nxt;
  logic [15:0] instr_r, instr_nxt;
  logic [FA_W-1:0] addr_r, addr_nxt;
  logic bad_r, bad_nxt;
  logic [DATA_W-1:0] opnd_r, opnd_nxt;
  logic [DATA_W-1:0] res_r, res_nxt;
  logic [ST_W-1:0] flg_r, flg_nxt;

  // software-visible state
  logic [DATA_W-1:0] accum_r, accum_nxt;
  logic [ST_W-1:0] status_r, status_nxt;
  logic [BANK_W-1:0] bank_r, bank_nxt;
  logic ext_en_r, ext_en_nxt;
  logic [FA_W-1:0] idx_r, idx_nxt;
  logic [FA_W-1:0] maddr_r, maddr_nxt;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;

  // file store
  logic [DATA_W-1:0] file_mem [FILE_DEPTH];
  logic mem_we;
  logic [FA_W-1:0] mem_wa;
  logic [DATA_W-1:0] mem_wd;

  logic take;
  logic hw_write;
  logic [DATA_W-1:0] alu_diff;
  logic [ST_W-1:0] alu_flags;

  // flag generator works from the latched operand
  swb_flags u_flags (
    .minuend(opnd_r),
    .subtrahend(accum_r),
    .carry_in(status_r[ST_C]),
    .diff(alu_diff),
    .flags(alu_flags)
  );

  // handshake toward the core
  assign instr_ready = (state_r == SWB_IDLE) || (state_r == SWB_Q4);
  assign take = instr_valid && instr_ready;
  assign busy = (state_r != SWB_IDLE);
  assign hw_write = (state_r == SWB_Q4) && !bad_r;
  assign done = hw_write;
  assign ill_op = (state_r == SWB_Q4) && bad_r;
  assign accum_out = accum_r;
  assign status_out = status_r;
  assign bus_rdata = rdata_r;

  // phase sequencing and datapath next values
  always_comb begin
    state_nxt = state_r;
    instr_nxt = instr_r;
    addr_nxt = addr_r;
    bad_nxt = bad_r;
    opnd_nxt = opnd_r;
    res_nxt = res_r;
    flg_nxt = flg_r;
    if (take) begin
      instr_nxt = instr_word;
    end
    unique case (state_r)
      SWB_IDLE: begin
        if (take) begin
          state_nxt = SWB_Q1;
        end
      end
      SWB_Q1: begin
        // decode: opcode check and address resolution
        state_nxt = SWB_Q2;
        bad_nxt = (instr_r[15:OP_LSB] != OPC_TOP);
        addr_nxt = resolve_addr(instr_r[7:0], instr_r[A_BIT], bank_r,
                                ext_en_r, idx_r);
      end
      SWB_Q2: begin
        // read the file operand
        state_nxt = SWB_Q3;
        opnd_nxt = file_mem[addr_r];
      end
      SWB_Q3: begin
        // compute result and flags
        state_nxt = SWB_Q4;
        res_nxt = alu_diff;
        flg_nxt = alu_flags;
      end
      SWB_Q4: begin
        // write back, then start the next cycle at once if offered
        state_nxt = take ? SWB_Q1 : SWB_IDLE;
      end
      default: begin
        state_nxt = SWB_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= SWB_IDLE;
      instr_r <= 16'h0000;
      addr_r <= '0;
      bad_r <= 1'b0;
      opnd_r <= 8'h00;
      res_r <= 8'h00;
      flg_r <= '0;
    end else begin
      state_r <= state_nxt;
      instr_r <= instr_nxt;
      addr_r <= addr_nxt;
      bad_r <= bad_nxt;
      opnd_r <= opnd_nxt;
      res_r <= res_nxt;
      flg_r <= flg_nxt;
    end
  end

  // software registers: bus writes first, write-back phase overrides status and, when the D bit is clear, the accumulator
  always_comb begin
    accum_nxt = accum_r;
    status_nxt = status_r;
    bank_nxt = bank_r;
    ext_en_nxt = ext_en_r;
    idx_nxt = idx_r;
    maddr_nxt = maddr_r;
    if (bus_wr) begin
      unique case (bus_addr)
        OFS_ACCUM: accum_nxt = bus_wdata;
        OFS_STATUS: status_nxt = bus_wdata[ST_W-1:0];
        OFS_BANK: bank_nxt = bus_wdata[BANK_W-1:0];
        OFS_CTRL: ext_en_nxt = bus_wdata[0];
        OFS_IDX_LO: idx_nxt[7:0] = bus_wdata;
        OFS_IDX_HI: idx_nxt[FA_W-1:8] = bus_wdata[FA_W-9:0];
        OFS_MADDR_LO: maddr_nxt[7:0] = bus_wdata;
        OFS_MADDR_HI: maddr_nxt[FA_W-1:8] = bus_wdata[FA_W-9:0];
        default: begin
        end
      endcase
    end
    if (hw_write) begin
      status_nxt = flg_r;
      if (!instr_r[D_BIT]) begin
        accum_nxt = res_r;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      accum_r <= RST_ACCUM;
      status_r <= RST_STATUS;
      bank_r <= RST_BANK;
      ext_en_r <= RST_EXT_EN;
      idx_r <= RST_IDX;
      maddr_r <= RST_IDX;
    end else begin
      accum_r <= accum_nxt;
      status_r <= status_nxt;
      bank_r <= bank_nxt;
      ext_en_r <= ext_en_nxt;
      idx_r <= idx_nxt;
      maddr_r <= maddr_nxt;
    end
  end

  // file write port: write-back wins over a bus store in the same cycle
  always_comb begin
    mem_we = bus_wr && (bus_addr == OFS_MDATA);
    mem_wa = maddr_r;
    mem_wd = bus_wdata;
    if (hw_write && instr_r[D_BIT]) begin
      mem_we = 1'b1;
      mem_wa = addr_r;
      mem_wd = res_r;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (mem_we) begin
      file_mem[mem_wa] <= mem_wd;
    end
  end

  // read data stands only in the cycle after the strobe
  always_comb begin
    rdata_nxt = 8'h00;
    if (bus_rd) begin
      unique case (bus_addr)
        OFS_ACCUM: rdata_nxt = accum_r;
        OFS_STATUS: rdata_nxt = {3'h0, status_r};
        OFS_BANK: rdata_nxt = {4'h0, bank_r};
        OFS_CTRL: rdata_nxt = {7'h00, ext_en_r};
        OFS_IDX_LO: rdata_nxt = idx_r[7:0];
        OFS_IDX_HI: rdata_nxt = {4'h0, idx_r[FA_W-1:8]};
        OFS_MADDR_LO: rdata_nxt = maddr_r[7:0];
        OFS_MADDR_HI: rdata_nxt = {4'h0, maddr_r[FA_W-1:8]};
        OFS_MDATA: rdata_nxt = file_mem[maddr_r];
        OFS_PHASE: rdata_nxt = {3'h0, state_r};
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // assertions
  sequence q_walk_s;
    (state_r == SWB_Q2) ##1 (state_r == SWB_Q3) ##1 (state_r == SWB_Q4);
  endsequence

  sequence good_wb_s;
    (state_r == SWB_Q4) && !bad_r;
  endsequence

  phase_walk_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (state_r == SWB_Q1) |=> q_walk_s)
    else $error("phase order broken");

  take_start_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    take |=> (state_r == SWB_Q1) ##3 (state_r == SWB_Q4))
    else $error("instruction did not finish in one cycle of four phases");

  opcode_check_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (state_r == SWB_Q1) |=> (bad_r == ($past(instr_r[15:OP_LSB]) != 6'h16)))
    else $error("opcode recognition wrong");

  sub_value_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (state_r == SWB_Q3) |=>
      res_r == 8'($past(opnd_r) - $past(accum_r) - {7'h00, !$past(status_r[ST_C])}))
    else $error("difference wrong");

  flag_update_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    good_wb_s |=> (status_r[ST_Z] == (($past(res_r)) == 8'h00))
      && (status_r[ST_N] == $past(res_r[7])))
    else $error("zero or negative flag wrong");

  carry_flag_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (state_r == SWB_Q3) |=> ##1
      (status_r[ST_C] == ($past(opnd_r, 2) >= ({1'b0, $past(accum_r, 2)}
        + {8'h00, !$past(status_r[ST_C], 2)})) || bad_r))
    else $error("carry flag wrong");

  acc_dest_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    good_wb_s and (!instr_r[D_BIT]) |=> accum_r == $past(res_r))
    else $error("accumulator not written");

  acc_hold_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    good_wb_s and (instr_r[D_BIT] && !(bus_wr && bus_addr == OFS_ACCUM)) |=> $stable(accum_r))
    else $error("accumulator changed on file destination");

  file_dest_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    good_wb_s and (instr_r[D_BIT]) |=> file_mem[$past(addr_r)] == $past(res_r))
    else $error("file location not written");

  bank_addr_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (state_r == SWB_Q1) && instr_r[A_BIT] |=> addr_r == {$past(bank_r), $past(instr_r[7:0])})
    else $error("banked address wrong");

  quick_addr_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (state_r == SWB_Q1) && !instr_r[A_BIT] && !(ext_en_r && instr_r[7:0] <= IDX_LIMIT)
      |=> addr_r[7:0] == $past(instr_r[7:0])
      && (addr_r[FA_W-1:8] == ($past(instr_r[7]) ? ACCESS_HI_BANK : ACCESS_LO_BANK)))
    else $error("quick bank address wrong");

  indexed_addr_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (state_r == SWB_Q1) && !instr_r[A_BIT] && ext_en_r && (instr_r[7:0] <= IDX_LIMIT)
      |=> addr_r == 12'($past(idx_r) + {4'h0, $past(instr_r[7:0])}))
    else $error("indexed address wrong");

endmodule : swb_unit
